// ==== return_instruction_unit_test.sv ====
/*
  Self-checking bench for the return instruction unit (rtu_core).
  Assumes a take at the internal Q1 enable and answers on pc_load_q.
*/
`timescale 1ns/1ps
module return_instruction_unit_test
  import rtu_pkg::*;
;
  typedef struct {
    logic [20:0]  pc;
    logic [12:0]  we;
    logic [103:0] d;
    logic [4:0]   f;
  } rtu_exp_t;

  logic         ref_clk;
  logic         rst_n;
  logic         instr_valid;
  logic [15:0]  instr_word;
  logic [20:0]  stack_top;
  logic [1:0]   cpu_state;
  logic [1:0]   resume_state;
  logic [103:0] shadow_main;
  logic [103:0] shadow_low;
  logic [23:0]  fast_q;
  logic [20:0]  pc_q;
  logic         pc_load_q;
  logic         stack_pop_q;
  logic [103:0] ctx_data_q;
  logic [12:0]  ctx_we_q;
  logic         gie_hi;
  logic         gie_lo;
  logic [1:0]   stat_q;
  logic         stat_we_q;
  logic         busy_q;
  int           fails;
  int           samples_checked;
  int           cyc;
  int           bcnt;
  rtu_exp_t     q[$];

  rtu_core #(.PC_W(21)) rtu_core_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .stack_top(stack_top),
    .cpu_state(cpu_state), .resume_state(resume_state),
    .shadow_main(shadow_main), .shadow_low(shadow_low),
    .fast_shadow_working(fast_q[7:0]), .fast_shadow_status(fast_q[15:8]),
    .fast_shadow_bank(fast_q[23:16]), .pc_q(pc_q), .pc_load_q(pc_load_q),
    .stack_pop_q(stack_pop_q), .ctx_data_q(ctx_data_q), .ctx_we_q(ctx_we_q),
    .global_irq_en_high_q(gie_hi), .global_irq_en_low_q(gie_lo),
    .stat_q(stat_q), .stat_we_q(stat_we_q), .busy_q(busy_q)
  );

  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic cmp_vec(input logic [127:0] g, input logic [127:0] x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("FAIL t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [103:0] slot_mask(input logic [12:0] we);
    logic [103:0] m;
    m = '0;
    for (int i = 0; i < 13; i++) m[8*i +: 8] = {8{we[i]}};
    return m;
  endfunction

  // Hold the word a full instruction cycle (or two, to probe refusal);
  // the context inputs stay put until the unit is idle again
  task automatic issue(input logic [15:0] w, input int hold,
                       input bit res, input logic [3:0] cr);
    rtu_exp_t     e;
    logic [20:0]  st;
    logic [103:0] sm;
    logic [103:0] sl;
    logic [23:0]  fz;
    st = 21'($urandom);
    sm = 104'({$urandom, $urandom, $urandom, $urandom});
    sl = 104'({$urandom, $urandom, $urandom, $urandom});
    fz = 24'($urandom);
    e.pc = st;
    e.we = 13'h0000;
    e.d = '0;
    e.f = 5'h00;
    if (w[15:1] == 15'h0008) begin
      e.we = w[0] ? 13'h1fff : 13'h0000;
      e.d = (cr[1:0] == 2'h1) ? sl : sm;
      e.f = {cr[3], ~cr[3], 1'b1, cr[1:0]};
    end else if (w[15:1] == 15'h0080) begin
      e.we = w[0] ? 13'h0007 : 13'h0000;
      e.d[23:0] = fz;
    end else begin
      e.we = 13'h0001;
      e.d[7:0] = w[7:0];
    end
    @(posedge ref_clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    stack_top <= st;
    shadow_main <= sm;
    shadow_low <= sl;
    fast_q <= fz;
    {cpu_state, resume_state} <= cr;
    if (res) q.push_back(e);
    repeat (hold) @(posedge ref_clk);
    instr_valid <= 1'b0;
    @(posedge ref_clk);
    #1;
    for (int i = 0; i < 20 && busy_q === 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  // Scoreboard: each load pulse consumes the oldest expectation
  always @(negedge ref_clk) begin
    rtu_exp_t    e;
    logic [16:0] stray;
    stray = {ctx_we_q, stack_pop_q, gie_hi, gie_lo, stat_we_q};
    if (pc_load_q === 1'b1) begin
      if (q.size() == 0) begin
        cmp_vec(128'(pc_load_q), 128'h0);
      end else begin
        e = q.pop_front();
        cmp_vec(128'(pc_q), 128'(e.pc));
        cmp_vec(128'(stack_pop_q), 128'h1);
        cmp_vec(128'(ctx_we_q), 128'(e.we));
        cmp_vec(128'(ctx_data_q & slot_mask(e.we)),
                128'(e.d & slot_mask(e.we)));
        cmp_vec(128'({gie_hi, gie_lo, stat_we_q}), 128'(e.f[4:2]));
        if (e.f[2]) cmp_vec(128'(stat_q), 128'(e.f[1:0]));
      end
    end else if (stray !== 17'h00000) begin
      cmp_vec(128'(stray), 128'h0);
    end
    // Busy rises on the take edge, so the Q1 of cycle one is not counted
    if (busy_q === 1'b1) bcnt++;
    else if (bcnt != 0) begin
      cmp_vec(128'(bcnt), 128'(2 * RTU_Q_PHASES - 1));
      bcnt = 0;
    end
  end

  // Hang guard, well above the roughly 600 cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    stack_top = '0;
    cpu_state = 2'h0;
    resume_state = 2'h0;
    shadow_main = '0;
    shadow_low = '0;
    fast_q = '0;
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    bcnt = 0;
    void'($urandom(30));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Every flag, priority and resume state combination
    for (int k = 0; k < 32; k++) issue(16'h0010 | 16'(k[4]), 4, 1, k[3:0]);
    $display("test interrupt return done");
    for (int k = 0; k < 6; k++)
      issue({8'h0c, (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom)},
            4, 1, 4'($urandom));
    $display("test literal return done");
    for (int k = 0; k < 4; k++)
      issue(16'h0100 | 16'(k[0]), 4, 1, 4'($urandom));
    $display("test subroutine return done");
    // Near-miss words must be ignored entirely
    issue(16'h0014, 4, 0, 4'h0);
    issue(16'h0111, 4, 0, 4'h0);
    issue(16'h0d00, 4, 0, 4'h0);
    issue(16'h0001, 4, 0, 4'h0);
    issue(16'h0012, 4, 0, 4'h0);
    $display("test ignored words done");
    // Second Q1 lands while busy: only one return may come out
    issue(16'h0101, 8, 1, 4'h5);
    issue(16'h0011, 8, 1, 4'h9);
    $display("test busy refusal done");
    repeat (20) @(posedge ref_clk);
    cmp_vec(128'(q.size()), 128'h0);
    test_done();
  end
endmodule

// ==== rtu_core.sv ====
/*
  Return instruction unit: executes interrupt return, literal return and
  subroutine return. Drives the program counter, stack pop, context
  restore bus, interrupt enable set pulses and the operating state field.
  Assumes the decoder presents a word with instr_valid on the Q1 enable,
  and that stack, shadow sets and interrupt controller sample the pulses.
*/
// Operation
// - Interrupt return pops the stack and loads the popped top into PC.
// - Interrupt return sets high or low global enable at Q4, cycle one.
// - Flagged interrupt return restores all thirteen context registers.
// - Two shadow sets, main and low; pick one by operating state.
// - Unflagged interrupt return writes no context; only PC, stack, enable and state.
// - Interrupt return updates the two-bit operating state field only.
// - Literal return writes its byte to working register; two cycles.
// - Literal return loads PC from stack top; PC latches untouched.
// - Subroutine return pops stack into PC over two cycles.
// - Flagged subroutine return restores working, status, bank from fast.
// - Unflagged subroutine return leaves working, status, bank alone.
`timescale 1ns/1ps
module rtu_core
  import rtu_pkg::*;
#(
  parameter int PC_W = RTU_PC_W_DOC
)(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   instr_valid,
  input  wire logic [15:0]            instr_word,
  input  wire logic [PC_W-1:0]        stack_top,
  input  wire logic [1:0]             cpu_state,
  input  wire logic [1:0]             resume_state,
  input  wire logic [RTU_CTX_N*8-1:0] shadow_main,
  input  wire logic [RTU_CTX_N*8-1:0] shadow_low,
  input  wire logic [7:0]             fast_shadow_working,
  input  wire logic [7:0]             fast_shadow_status,
  input  wire logic [7:0]             fast_shadow_bank,
  output logic [PC_W-1:0]             pc_q,
  output logic                        pc_load_q,
  output logic                        stack_pop_q,
  output logic [RTU_CTX_N*8-1:0]      ctx_data_q,
  output logic [RTU_CTX_N-1:0]        ctx_we_q,
  output logic                        global_irq_en_high_q,
  output logic                        global_irq_en_low_q,
  output logic [1:0]                  stat_q,
  output logic                        stat_we_q,
  output logic                        busy_q
);
  if (PC_W < 1 || PC_W > RTU_PC_W_DOC) begin : g_chk
    $error("rtu_core: PC_W out of range");
  end

  logic q1_en;
  logic q4_en;

  rtu_qphase rtu_qphase_i (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .q1_en   (q1_en),
    .q4_en   (q4_en)
  );

  rtu_state_t              state_q, state_d;
  rtu_kind_t               kind_q, kind_d;
  logic                    flag_q, flag_d;
  logic [7:0]              lit_q, lit_d;
  logic [PC_W-1:0]         pc_d;
  logic                    pc_load_d;
  logic [RTU_CTX_N*8-1:0]  ctx_data_d;
  logic [RTU_CTX_N-1:0]    ctx_we_d;
  logic                    gie_h_d, gie_l_d;
  logic [1:0]              stat_d;
  logic                    stat_we_d;
  logic                    is_iret, is_sret, is_lret;
  logic [RTU_CTX_N-1:0]    fast_mask;

  // Opcode decode; subroutine return carries its flag in bit 0
  assign is_iret = (instr_word[15:1] == RTU_OP_IRET_HI);
  assign is_sret = (instr_word[15:1] == RTU_OP_SRET_HI);
  assign is_lret = (instr_word[15:8] == RTU_OP_LRET_HI);
  assign fast_mask = RTU_CTX_N'(7);  // working, status, bank slots

  // Sequencer and execute; all effects land on the Q4 of cycle one,
  // cycle two is a dead cycle so the fetch pipeline can refill
  always_comb begin
    state_d    = state_q;
    kind_d     = kind_q;
    flag_d     = flag_q;
    lit_d      = lit_q;
    pc_d       = pc_q;
    pc_load_d  = 1'b0;
    ctx_data_d = ctx_data_q;
    ctx_we_d   = '0;
    gie_h_d    = 1'b0;
    gie_l_d    = 1'b0;
    stat_d     = stat_q;
    stat_we_d  = 1'b0;
    case (state_q)
      RTU_ST_IDLE: begin
        if (q1_en && instr_valid && (is_iret || is_sret || is_lret)) begin
          state_d = RTU_ST_EXEC;
          kind_d  = is_iret ? RTU_OP_IRET :
                    (is_lret ? RTU_OP_LRET : RTU_OP_NONE);
          flag_d  = !is_lret && instr_word[RTU_FLAG_BIT];
          lit_d   = instr_word[7:0];
        end
      end
      RTU_ST_EXEC: begin
        if (q4_en) begin
          state_d   = RTU_ST_NOP;
          pc_d      = stack_top;
          pc_load_d = 1'b1;
          case (kind_q)
            RTU_OP_IRET: begin
              gie_h_d   = cpu_state[RTU_CPU_HIGH_BIT];
              gie_l_d   = !cpu_state[RTU_CPU_HIGH_BIT];
              stat_d    = resume_state;
              stat_we_d = 1'b1;
              if (flag_q) begin
                // Set is chosen by the state being resumed
                ctx_data_d = (resume_state == RTU_CPU_LOW) ?
                             shadow_low : shadow_main;
                ctx_we_d   = '1;
              end
            end
            RTU_OP_LRET: begin
              // Only the working slot is written; latches keep value
              ctx_data_d[RTU_SLOT_WORK*8 +: 8] = lit_q;
              ctx_we_d[RTU_SLOT_WORK] = 1'b1;
            end
            default: begin
              if (flag_q) begin
                ctx_data_d[RTU_SLOT_WORK*8 +: 8] = fast_shadow_working;
                ctx_data_d[RTU_SLOT_STAT*8 +: 8] = fast_shadow_status;
                ctx_data_d[RTU_SLOT_BANK*8 +: 8] = fast_shadow_bank;
                ctx_we_d = fast_mask;
              end
            end
          endcase
        end
      end
      RTU_ST_NOP: begin
        if (q4_en) begin
          state_d = RTU_ST_IDLE;
        end
      end
      default: begin
        state_d = RTU_ST_IDLE;
      end
    endcase
  end

  // Registers; every output is a flop so downstream timing is clean
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q              <= RTU_ST_IDLE;
      kind_q               <= RTU_OP_NONE;
      flag_q               <= 1'b0;
      lit_q                <= 8'h00;
      pc_q                 <= '0;
      pc_load_q            <= 1'b0;
      stack_pop_q          <= 1'b0;
      ctx_data_q           <= '0;
      ctx_we_q             <= '0;
      global_irq_en_high_q <= 1'b0;
      global_irq_en_low_q  <= 1'b0;
      stat_q               <= RTU_STAT_RST;
      stat_we_q            <= 1'b0;
      busy_q               <= 1'b0;
    end else begin
      state_q              <= state_d;
      kind_q               <= kind_d;
      flag_q               <= flag_d;
      lit_q                <= lit_d;
      pc_q                 <= pc_d;
      pc_load_q            <= pc_load_d;
      stack_pop_q          <= pc_load_d;
      ctx_data_q           <= ctx_data_d;
      ctx_we_q             <= ctx_we_d;
      global_irq_en_high_q <= gie_h_d;
      global_irq_en_low_q  <= gie_l_d;
      stat_q               <= stat_d;
      stat_we_q            <= stat_we_d;
      busy_q               <= (state_d != RTU_ST_IDLE);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_POP_TO_PC: assert property (
    pc_load_q |-> stack_pop_q && pc_q == $past(stack_top))
    else $error("PC not loaded from popped stack top");
  AST_GIE_AT_Q4: assert property (
    $rose(global_irq_en_high_q || global_irq_en_low_q) |->
      $past(q4_en) && $past(state_q) == RTU_ST_EXEC
      && $past(kind_q) == RTU_OP_IRET
      && global_irq_en_high_q == $past(cpu_state[RTU_CPU_HIGH_BIT]))
    else $error("Global enable set at wrong time or level");
  AST_IRET_FULL: assert property (
    pc_load_q && $past(kind_q) == RTU_OP_IRET && $past(flag_q) |->
      ctx_we_q == '1)
    else $error("Flagged interrupt return missed a context slot");
  AST_SET_PICK: assert property (
    pc_load_q && $past(kind_q) == RTU_OP_IRET && $past(flag_q) |->
      ctx_data_q == (($past(resume_state) == RTU_CPU_LOW) ?
                     $past(shadow_low) : $past(shadow_main)))
    else $error("Wrong shadow set restored");
  AST_IRET_QUIET: assert property (
    pc_load_q && $past(kind_q) == RTU_OP_IRET && !$past(flag_q) |->
      ctx_we_q == '0)
    else $error("Unflagged interrupt return wrote context");
  AST_STAT_UPD: assert property (
    stat_we_q |-> stat_q == $past(resume_state) && pc_load_q
      && (global_irq_en_high_q ^ global_irq_en_low_q))
    else $error("State field not updated with interrupt return");
  AST_LIT_WRITE: assert property (
    pc_load_q && $past(kind_q) == RTU_OP_LRET |->
      ctx_we_q == RTU_CTX_N'(1) && ctx_data_q[7:0] == $past(lit_q))
    else $error("Literal not written to working register");
  AST_LIT_LATCH: assert property (
    pc_load_q && $past(kind_q) == RTU_OP_LRET |->
      !ctx_we_q[RTU_SLOT_PCLH] && !ctx_we_q[RTU_SLOT_PCLU])
    else $error("Literal return touched PC latches");
  AST_TWO_CYC: assert property (
    pc_load_q |-> busy_q ##1 busy_q[*3] ##1 !busy_q)
    else $error("Return did not take two instruction cycles");
  AST_FAST_REST: assert property (
    pc_load_q && $past(kind_q) == RTU_OP_NONE && $past(flag_q) |->
      ctx_we_q == fast_mask
      && ctx_data_q[15:8] == $past(fast_shadow_status))
    else $error("Fast shadow restore wrong");
  AST_SRET_QUIET: assert property (
    pc_load_q && $past(kind_q) == RTU_OP_NONE && !$past(flag_q) |->
      ctx_we_q == '0)
    else $error("Unflagged subroutine return wrote context");
  AST_SRET_FLAG: assert property (
    state_q == RTU_ST_IDLE && q1_en && instr_valid
      && instr_word[15:1] == RTU_OP_SRET_HI |=>
      state_q == RTU_ST_EXEC && kind_q == RTU_OP_NONE
      && flag_q == $past(instr_word[0]))
    else $error("Subroutine return flag not captured");
endmodule

// ==== rtu_pkg.sv ====
/*
  Shared constants for the return instruction unit: opcode patterns,
  context register slots, operating states and reset values.
  Assumes a 16-bit instruction word and one 8-bit byte per context slot.
*/
package rtu_pkg;
  // Opcode patterns, flag bit masked off (upper 15 bits compared); literal return compares upper 8 bits
  localparam logic [14:0] RTU_OP_IRET_HI = 15'h0008;
  // Subroutine return: upper twelve bits 0x010, bits 3:1 fixed at zero
  localparam logic [14:0] RTU_OP_SRET_HI = 15'h0080;
  localparam logic [7:0]  RTU_OP_LRET_HI = 8'h0c;
  localparam int          RTU_FLAG_BIT   = 0;

  // Context slots in the restore bus, one byte each
  localparam int RTU_CTX_N      = 13;
  localparam int RTU_SLOT_WORK  = 0;
  localparam int RTU_SLOT_STAT  = 1;
  localparam int RTU_SLOT_BANK  = 2;
  localparam int RTU_SLOT_P0H   = 3;
  localparam int RTU_SLOT_P0L   = 4;
  localparam int RTU_SLOT_P1H   = 5;
  localparam int RTU_SLOT_P1L   = 6;
  localparam int RTU_SLOT_P2H   = 7;
  localparam int RTU_SLOT_P2L   = 8;
  localparam int RTU_SLOT_PROD_HI = 9;
  localparam int RTU_SLOT_PROD_LO = 10;
  localparam int RTU_SLOT_PCLH  = 11;
  localparam int RTU_SLOT_PCLU  = 12;

  // Operating state field values
  localparam logic [1:0] RTU_CPU_MAIN = 2'h0;
  localparam logic [1:0] RTU_CPU_LOW  = 2'h1;
  localparam int         RTU_CPU_HIGH_BIT = 1;

  // Reset value, document PC width, quarter phases per cycle
  localparam logic [1:0] RTU_STAT_RST = 2'h0;
  localparam int         RTU_PC_W_DOC = 21;
  localparam int         RTU_Q_PHASES = 4;

  typedef enum logic [2:0] {
    RTU_ST_IDLE = 3'h1,
    RTU_ST_EXEC = 3'h2,
    RTU_ST_NOP  = 3'h4
  } rtu_state_t;

  typedef enum logic [2:0] {
    RTU_OP_NONE = 3'h1,
    RTU_OP_IRET = 3'h2,
    RTU_OP_LRET = 3'h4
  } rtu_kind_t;
endpackage

// ==== rtu_qphase.sv ====
/*
  Quarter-phase generator: one ref_clk cycle per quarter of an
  instruction cycle, giving one-cycle Q1 and Q4 enable pulses.
  Assumes the core advances only on these enables.
*/
`timescale 1ns/1ps
module rtu_qphase
  import rtu_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  output logic      q1_en,
  output logic      q4_en
);
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic       q1_d;
  logic       q4_d;

  // Next phase; Q4 enable precedes Q1 so an instruction starts cleanly
  always_comb begin
    phase_d = phase_q + 2'h1;
    q1_d    = (phase_d == 2'h0);
    q4_d    = (phase_d == 2'(RTU_Q_PHASES - 1));
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
      q1_en   <= 1'b0;
      q4_en   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      q1_en   <= q1_d;
      q4_en   <= q4_d;
    end
  end
endmodule
